// File: common/msp_port_regs.vh
// Purpose: shared constants of the media-independent / symbol port
// Assumes: included by bare name from core files
// Notes: definitions only; times are in ns and turned into cycles by the user
`ifndef MSP_PORT_REGS_VH
`define MSP_PORT_REGS_VH

// ****************************************
// clock and timing
// ****************************************
`define MSP_SYS_PERIOD_NS 25
`define MSP_MDC_MIN_PERIOD_NS 400

// ****************************************
// data path layout
// ****************************************
`define MSP_NIB_W 4
`define MSP_SYM_W 5
`define MSP_SYM_BIT 4
`define MSP_RXW_ERR 5
`define MSP_RXW_SOF 6
`define MSP_RXW_W 7
`define MSP_TXW_ERR 5
`define MSP_TXW_LAST 6
`define MSP_TXW_W 7
`define MSP_SYM_HALT 5'h04

// ****************************************
// management frame layout
// ****************************************
`define MSP_MDIO_FRAME_BITS 64
`define MSP_MDIO_CNT_W 6
`define MSP_MDIO_LAST_BIT 6'h3F
`define MSP_MDIO_RD_DRIVE_BITS 6'h2E
`define MSP_MDIO_RD_DATA_FIRST 6'h30
`define MSP_MDIO_PREAMBLE 32'hFFFFFFFF
`define MSP_MDIO_START 2'h1
`define MSP_MDIO_OP_WR 2'h1
`define MSP_MDIO_OP_RD 2'h2
`define MSP_MDIO_TA_WR 2'h2

`endif

// File: core/msp_pair_buf.v
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: one clock, synchronous active-high reset
// Notes: head entry and flags are flip-flops so outputs come straight from flops
`timescale 1ns/1ps
`default_nettype none

module msp_pair_buf #(
	parameter WIDTH = 7
) (
	input wire sys_clk_i,
	input wire srst_i,
	input wire in_valid_i,
	input wire [WIDTH-1:0] in_data_i,
	output reg in_ready_o,
	output reg out_valid_o,
	output reg [WIDTH-1:0] out_data_o,
	input wire out_ready_i
);

	reg [WIDTH-1:0] slot1; // second entry, behind the head
	reg full1; // second entry holds a word
	wire push; // word accepted this cycle
	wire pop; // head taken this cycle
	reg next_full1;

	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// occupancy of the second slot after this cycle
	always @* begin
		next_full1 = full1;
		if (pop & ~push) begin
			next_full1 = 1'b0;
		end else if (push & ~pop & out_valid_o) begin
			next_full1 = 1'b1;
		end
	end

	// shift on pop, fill the lowest free slot on push
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			out_valid_o <= 1'b0;
			full1 <= 1'b0;
			in_ready_o <= 1'b0;
			out_data_o <= {WIDTH{1'b0}};
			slot1 <= {WIDTH{1'b0}};
		end else begin
			full1 <= next_full1;
			// ready is registered, so a full buffer refuses for a whole cycle
			in_ready_o <= ~next_full1;
			if (pop) begin
				out_data_o <= full1 ? slot1 : in_data_i;
				out_valid_o <= full1 | push;
				if (full1 & push) begin
					slot1 <= in_data_i;
				end
			end else if (push) begin
				if (~out_valid_o) begin
					out_data_o <= in_data_i;
					out_valid_o <= 1'b1;
				end else begin
					slot1 <= in_data_i;
				end
			end
		end
	end

endmodule // msp_pair_buf

`default_nettype wire

// File: core/msp_mii_port.v
// Purpose: MAC-side logic of the media-independent / symbol port
// Assumes: link clocks well below half of sys_clk_i; all pins are asynchronous
// Notes: link clocks are sampled as data, no second clock domain is used
`timescale 1ns/1ps
`default_nettype none
`include "msp_port_regs.vh"

module msp_mii_port #(
	parameter MDC_MIN_PERIOD_NS = `MSP_MDC_MIN_PERIOD_NS
) (
	input wire sys_clk_i,
	input wire srst_i,
	// mode select from local logic
	input wire sym_mode_i,
	// receive pins from the PHY
	input wire rx_clk_i,
	input wire [4:0] rxd_i,
	input wire rx_data_valid_in_i,
	input wire rx_err_i,
	input wire crs_i,
	input wire col_i,
	input wire signal_detect_in_i,
	// transmit pins to the PHY
	input wire tx_clk_i,
	output reg [4:0] txd_o,
	output reg tx_en_o,
	// management pins
	output reg mdc_o,
	input wire mdio_i,
	output reg mdio_o,
	output reg mdio_oe_o,
	// receive stream to the MAC
	output wire rx_valid_o,
	output wire [4:0] rx_data_o,
	output wire rx_err_o,
	output wire rx_sof_o,
	input wire rx_ready_i,
	output reg rx_overflow_o,
	// transmit stream from the MAC
	input wire tx_valid_i,
	input wire [4:0] tx_data_i,
	input wire tx_err_i,
	input wire tx_last_i,
	output wire tx_ready_o,
	output reg tx_underrun_o,
	// line status
	output reg crs_o,
	output reg col_o,
	output reg signal_detect_o,
	// management command port
	input wire mdio_start_i,
	input wire mdio_write_i,
	input wire [4:0] mdio_phy_i,
	input wire [4:0] mdio_reg_i,
	input wire [15:0] mdio_wdata_i,
	output reg mdio_busy_o,
	output reg mdio_done_o,
	output reg [15:0] mdio_rdata_o
);

	// ****************************************
	// constants
	// ****************************************
	// half period of the management clock, rounded up so the period is never short
	localparam integer MDC_HALF = (MDC_MIN_PERIOD_NS + 2 * `MSP_SYS_PERIOD_NS - 1)
		/ (2 * `MSP_SYS_PERIOD_NS);
	localparam [7:0] MDC_HALF_M1 = MDC_HALF[7:0] - 8'h01;
	localparam ST_IDLE = 1'b0; // management engine waiting
	localparam ST_SHIFT = 1'b1; // management frame in progress
	localparam SYNC_W = 12; // txclk, rxclk, rxd[4:0], dv, err, crs, col, sd

	// mask the fifth bit away outside the symbol modes
	function [4:0] msp_width_mask;
		input [4:0] val;
		input sym;
		begin
			msp_width_mask = sym ? val : {1'b0, val[`MSP_NIB_W-1:0]};
		end
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	reg [SYNC_W-1:0] pin_s1; // first stage, read only by pin_s2
	reg [SYNC_W-1:0] pin_s2; // second stage, safe to use
	reg [SYNC_W-1:0] pin_d3; // one cycle older, for edges and pre-edge data
	reg mdio_s1; // first stage of the management input
	reg mdio_s2; // second stage of the management input
	wire rx_rise; // receive clock rose
	wire tx_fall; // transmit clock fell

	// all link pins pass the same two flops so they stay aligned with the clocks; mdio has its own pair
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			pin_s1 <= {SYNC_W{1'b0}};
			pin_s2 <= {SYNC_W{1'b0}};
			pin_d3 <= {SYNC_W{1'b0}};
			mdio_s1 <= 1'b0;
			mdio_s2 <= 1'b0;
		end else begin
			pin_s1 <= {tx_clk_i, rx_clk_i, rxd_i, rx_data_valid_in_i, rx_err_i,
				crs_i, col_i, signal_detect_in_i};
			pin_s2 <= pin_s1;
			pin_d3 <= pin_s2;
			mdio_s1 <= mdio_i;
			mdio_s2 <= mdio_s1;
		end
	end

	// edges seen on the second stage against the third
	assign rx_rise = pin_s2[10] & ~pin_d3[10];
	assign tx_fall = ~pin_s2[11] & pin_d3[11];

	// ****************************************
	// line status
	// ****************************************
	// status bits follow the PHY; signal detect means nothing outside symbol modes
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			crs_o <= 1'b0;
			col_o <= 1'b0;
			signal_detect_o <= 1'b0;
		end else begin
			crs_o <= pin_s2[2];
			col_o <= pin_s2[1];
			signal_detect_o <= sym_mode_i & pin_s2[0];
		end
	end

	// ****************************************
	// receive path
	// ****************************************
	reg rx_push; // captured word offered to the buffer
	reg [`MSP_RXW_W-1:0] rx_word; // {sof, err, data}
	reg rx_dv_prev; // data valid at the previous receive edge
	wire rx_buf_rdy; // buffer can take a word
	wire [`MSP_RXW_W-1:0] rx_buf_out;

	// capture the pre-edge values at each rising receive clock edge
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			rx_push <= 1'b0;
			rx_word <= {`MSP_RXW_W{1'b0}};
			rx_dv_prev <= 1'b0;
			rx_overflow_o <= 1'b0;
		end else begin
			rx_push <= 1'b0;
			rx_overflow_o <= 1'b0;
			if (rx_rise) begin
				rx_dv_prev <= pin_d3[4];
				// symbols stream without data valid; nibbles only inside a frame
				if (sym_mode_i | pin_d3[4]) begin
					rx_push <= 1'b1;
					rx_word[4:0] <= msp_width_mask(pin_d3[9:5], sym_mode_i);
					rx_word[`MSP_RXW_ERR] <= pin_d3[3];
					rx_word[`MSP_RXW_SOF] <= pin_d3[4] & ~rx_dv_prev;
				end
			end
			// a refused word is lost; flag it so the MAC can drop the frame
			if (rx_push & ~rx_buf_rdy) begin
				rx_overflow_o <= 1'b1;
			end
		end
	end

	msp_pair_buf #(
		.WIDTH(`MSP_RXW_W)
	) u_rx_buf (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.in_valid_i(rx_push),
		.in_data_i(rx_word),
		.in_ready_o(rx_buf_rdy),
		.out_valid_o(rx_valid_o),
		.out_data_o(rx_buf_out),
		.out_ready_i(rx_ready_i)
	);

	assign rx_data_o = rx_buf_out[4:0];
	assign rx_err_o = rx_buf_out[`MSP_RXW_ERR];
	assign rx_sof_o = rx_buf_out[`MSP_RXW_SOF];

	// ****************************************
	// transmit path
	// ****************************************
	wire tx_have; // buffered word ready to go
	wire [`MSP_TXW_W-1:0] tx_head;
	reg last_sent; // frame ended on the previous transmit edge
	wire tx_take; // head consumed on this edge
	wire [4:0] tx_sym; // data after error insertion

	// one idle nibble follows each frame so enable drops between frames
	assign tx_take = tx_fall & tx_have & ~last_sent;

	// errors are forced into the data itself: halt symbol or inverted nibble
	assign tx_sym = ~tx_head[`MSP_TXW_ERR] ? tx_head[4:0] :
		(sym_mode_i ? `MSP_SYM_HALT : {1'b0, ~tx_head[3:0]});

	// launch on the falling edge so the PHY samples stable data on the rise
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			txd_o <= 5'h00;
			tx_en_o <= 1'b0;
			last_sent <= 1'b0;
			tx_underrun_o <= 1'b0;
		end else begin
			tx_underrun_o <= 1'b0;
			if (tx_fall) begin
				if (tx_take) begin
					txd_o <= msp_width_mask(tx_sym, sym_mode_i);
					tx_en_o <= 1'b1;
					last_sent <= tx_head[`MSP_TXW_LAST];
				end else begin
					// an empty buffer mid-frame cuts the frame short
					if (tx_en_o & ~last_sent) begin
						tx_underrun_o <= 1'b1;
					end
					txd_o <= 5'h00;
					tx_en_o <= 1'b0;
					last_sent <= 1'b0;
				end
			end
		end
	end

	msp_pair_buf #(
		.WIDTH(`MSP_TXW_W)
	) u_tx_buf (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.in_valid_i(tx_valid_i),
		.in_data_i({tx_last_i, tx_err_i, tx_data_i}),
		.in_ready_o(tx_ready_o),
		.out_valid_o(tx_have),
		.out_data_o(tx_head),
		.out_ready_i(tx_take)
	);

	// ****************************************
	// management engine
	// ****************************************
	reg mstate; // engine state
	reg [7:0] half_cnt; // cycles left in this half of the clock
	reg [`MSP_MDIO_CNT_W-1:0] bit_cnt; // bit now on the line
	reg [`MSP_MDIO_FRAME_BITS-1:0] shreg; // frame, msb on the line
	reg rd_op; // current frame is a read
	reg [15:0] rd_shift; // read data gathered msb first
	wire half_end;

	assign half_end = (half_cnt == 8'h00);

	// frame: preamble, start, op, phy, reg, turnaround, data (64 clocks)
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			mstate <= ST_IDLE;
			half_cnt <= 8'h00;
			bit_cnt <= {`MSP_MDIO_CNT_W{1'b0}};
			shreg <= {`MSP_MDIO_FRAME_BITS{1'b0}};
			rd_op <= 1'b0;
			rd_shift <= 16'h0000;
			mdc_o <= 1'b0;
			mdio_o <= 1'b0;
			mdio_oe_o <= 1'b0;
			mdio_busy_o <= 1'b0;
			mdio_done_o <= 1'b0;
			mdio_rdata_o <= 16'h0000;
		end else begin
			mdio_done_o <= 1'b0;
			case (mstate)
			ST_IDLE: begin
				mdc_o <= 1'b0;
				mdio_oe_o <= 1'b0;
				// starts arriving while busy are ignored
				if (mdio_start_i) begin
					shreg <= {`MSP_MDIO_PREAMBLE, `MSP_MDIO_START,
						mdio_write_i ? `MSP_MDIO_OP_WR : `MSP_MDIO_OP_RD,
						mdio_phy_i, mdio_reg_i, `MSP_MDIO_TA_WR, mdio_wdata_i};
					rd_op <= ~mdio_write_i;
					bit_cnt <= {`MSP_MDIO_CNT_W{1'b0}};
					half_cnt <= MDC_HALF_M1;
					mdio_o <= 1'b1; // first preamble bit
					mdio_oe_o <= 1'b1;
					mdio_busy_o <= 1'b1;
					mstate <= ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (~half_end) begin
					half_cnt <= half_cnt - 8'h01;
				end else begin
					half_cnt <= MDC_HALF_M1;
					mdc_o <= ~mdc_o;
					if (~mdc_o) begin
						// rising edge: the PHY's read data is sampled here
						if (rd_op & (bit_cnt >= `MSP_MDIO_RD_DATA_FIRST)) begin
							rd_shift <= {rd_shift[14:0], mdio_s2};
						end
					end else if (bit_cnt == `MSP_MDIO_LAST_BIT) begin
						// falling edge after the last bit ends the frame
						mdio_oe_o <= 1'b0;
						mdio_o <= 1'b0;
						mdio_busy_o <= 1'b0;
						mdio_done_o <= 1'b1;
						if (rd_op) begin
							mdio_rdata_o <= rd_shift;
						end
						mstate <= ST_IDLE;
					end else begin
						// falling edge: next bit; reads release the line at turnaround
						bit_cnt <= bit_cnt + 6'h01;
						shreg <= {shreg[`MSP_MDIO_FRAME_BITS-2:0], 1'b0};
						mdio_o <= shreg[`MSP_MDIO_FRAME_BITS-2];
						mdio_oe_o <= ~rd_op | ((bit_cnt + 6'h01) < `MSP_MDIO_RD_DRIVE_BITS);
					end
				end
			end
			default: begin
				mstate <= ST_IDLE;
			end
			endcase
		end
	end

	// rate follows the PHY clocks alone; no speed setting exists here

endmodule // msp_mii_port

`default_nettype wire

// File: dv/msp_mii_port_props.sv
// Purpose: timing checks on the symbol port pins and streams
// Assumes: one system clock domain, 200 ns link clocks in the bench
// Notes: sees top ports only
`timescale 1ns/1ps
`default_nettype none
// ********
// checker
// ********
module msp_mii_port_props (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic sym_mode_i,
	input wire logic tx_clk_i,
	input wire logic [4:0] txd_o,
	input wire logic tx_en_o,
	input wire logic mdc_o,
	input wire logic mdio_busy_o,
	input wire logic mdio_done_o,
	input wire logic mdio_start_i,
	input wire logic signal_detect_o,
	input wire logic rx_valid_o,
	input wire logic rx_ready_i,
	input wire logic [4:0] rx_data_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	// transmit fifth bit and detect stay quiet in nibble mode
	property p_txd4; $past(!sym_mode_i) |-> !txd_o[4]; endproperty
	a_txd4: assert property (p_txd4) else $error("bit4 driven in nibble mode");
	property p_sd; !$past(sym_mode_i) |-> !signal_detect_o; endproperty
	a_sd: assert property (p_sd) else $error("detect seen in nibble mode");
	// management start, pulse and clock shape
	property p_busy; mdio_start_i && !mdio_busy_o |=> mdio_busy_o; endproperty
	a_busy: assert property (p_busy) else $error("start not taken");
	property p_done; mdio_done_o |=> !mdio_done_o; endproperty
	a_done: assert property (p_done) else $error("done longer than one cycle");
	property p_mdcq; !mdio_busy_o && !$past(mdio_busy_o) |-> !mdc_o; endproperty
	a_mdcq: assert property (p_mdcq) else $error("mdc runs while idle");
	property p_mdch; $rose(mdc_o) |=> mdc_o; endproperty
	a_mdch: assert property (p_mdch) else $error("mdc high too short");
	// enable spans at least four system cycles, half a link period; launch follows a falling link clock
	property p_ten; $rose(tx_en_o) |-> tx_en_o [*4]; endproperty
	a_ten: assert property (p_ten) else $error("enable dropped mid nibble");
	property p_launch; $changed(txd_o) |-> !$past(tx_clk_i, 3); endproperty
	a_launch: assert property (p_launch) else $error("data not on link clock");
	// a stalled word must not change
	property p_hold; rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o); endproperty
	a_hold: assert property (p_hold) else $error("stalled word lost");
	c_done: cover property (mdio_done_o);
	c_tx: cover property ($rose(tx_en_o));
	c_stall: cover property (rx_valid_o && !rx_ready_i);
endmodule // msp_mii_port_props
bind msp_mii_port msp_mii_port_props u_props (.sys_clk_i, .srst_i, .sym_mode_i, .tx_clk_i,
	.txd_o, .tx_en_o, .mdc_o, .mdio_busy_o, .mdio_done_o, .mdio_start_i, .signal_detect_o,
	.rx_valid_o, .rx_ready_i, .rx_data_o);
`default_nettype wire

// File: dv/msp_phy_model.sv
// Purpose: far-side transceiver model
// Assumes: 200 ns link clocks
// Notes: receive clock gives one idle period after a frame, then stands still
`timescale 1ns/1ps
`default_nettype none
// ********
// phy model
// ********
module msp_phy_model (
	output logic rx_clk_o,
	output logic [4:0] rxd_o,
	output logic dv_o,
	output logic err_o,
	output logic crs_o,
	output logic col_o,
	output logic sd_o,
	output logic tx_clk_o,
	input wire logic [4:0] txd_i,
	input wire logic tx_en_i,
	input wire logic mdc_i,
	input wire logic mdio_i,
	input wire logic mdio_oe_i,
	output logic mdio_o
);
	logic tx_run = 0; // transmit clock gate
	logic [4:0] tx_q[$]; // words taken while enabled
	logic [15:0] rd_word = 16'hA5C3; // read answer
	logic [15:0] cap = 16'h0000; // bits driven by the controller
	int k = 0; // rises since release
	initial begin
		{rx_clk_o, dv_o, err_o, crs_o, col_o, sd_o, tx_clk_o, rxd_o} = 0;
		mdio_o = 1;
	end
	// link clock, same rate both ways
	always #100 if (tx_run) tx_clk_o = ~tx_clk_o;
	always @(posedge tx_clk_o) if (tx_en_i) tx_q.push_back(txd_i);
	// one word per period, data set well before the rising edge, pins off sys edges
	task automatic send(input logic [4:0] d, input logic e);
		#5;
		rxd_o = d;
		dv_o = 1;
		err_o = e;
		#90 rx_clk_o = 1;
		#100 rx_clk_o = 0;
		#5;
	endtask
	// end of frame: one clocked period with valid low so the MAC sees the gap
	task automatic idle();
		#5;
		dv_o = 0;
		err_o = 0;
		rxd_o = ~rxd_o;
		#90 rx_clk_o = 1;
		#100 rx_clk_o = 0;
		#5;
	endtask
	// count rises after the controller lets go, answer msb first on falls
	always @(posedge mdc_i) k = mdio_oe_i ? 0 : k + 1;
	always @(negedge mdc_i) mdio_o <= (k >= 2 && k <= 17) ? rd_word[17 - k] : ~mdio_o;
	always @(posedge mdc_i) if (mdio_oe_i) cap <= {cap[14:0], mdio_i};
endmodule // msp_phy_model
`default_nettype wire

// File: dv/msp_mii_port_bench.sv
// Purpose: self-checking bench of the symbol port
// Assumes: 40 MHz system clock, short management clock
// Notes: one task per scenario
`timescale 1ns/1ps
`default_nettype none
// ********
// bench
// ********
module msp_mii_port_bench;
	logic sys_clk_i = 0, srst_i = 1, sym_mode_i = 0, rx_ready_i = 0, ovf = 0, und = 0;
	logic tx_valid_i = 0, tx_err_i = 0, tx_last_i = 0, mdio_start_i = 0, mdio_write_i = 0;
	logic [4:0] tx_data_i = 0, mdio_phy_i = 5'h03, mdio_reg_i = 5'h11;
	logic [15:0] mdio_wdata_i = 16'h3C96;
	logic [6:0] rx_q[$]; // accepted receive words
	wire [4:0] rxd_i, txd_o, rx_data_o;
	wire [15:0] mdio_rdata_o;
	wire rx_clk_i, rx_data_valid_in_i, rx_err_i, crs_i, col_i, signal_detect_in_i, tx_clk_i;
	wire tx_en_o, mdc_o, mdio_o, mdio_oe_o, rx_valid_o, rx_err_o, rx_sof_o, rx_overflow_o;
	wire tx_ready_o, crs_o, col_o, signal_detect_o, mdio_busy_o, mdio_done_o, phy_mdio;
	wire tx_underrun_o;
	wire mdio_i = mdio_oe_o ? mdio_o : phy_mdio; // shared line level
	int error_cnt = 0, checks_done = 0;
	msp_mii_port #(.MDC_MIN_PERIOD_NS(200)) dut (.sys_clk_i, .srst_i, .sym_mode_i, .rx_clk_i,
		.rxd_i, .rx_data_valid_in_i, .rx_err_i, .crs_i, .col_i, .signal_detect_in_i, .tx_clk_i,
		.txd_o, .tx_en_o, .mdc_o, .mdio_i, .mdio_o, .mdio_oe_o, .rx_valid_o, .rx_data_o,
		.rx_err_o, .rx_sof_o, .rx_ready_i, .rx_overflow_o, .tx_valid_i, .tx_data_i, .tx_err_i,
		.tx_last_i, .tx_ready_o, .tx_underrun_o, .crs_o, .col_o, .signal_detect_o,
		.mdio_start_i, .mdio_write_i, .mdio_phy_i, .mdio_reg_i, .mdio_wdata_i, .mdio_busy_o,
		.mdio_done_o, .mdio_rdata_o);
	msp_phy_model phy (.rx_clk_o(rx_clk_i), .rxd_o(rxd_i), .dv_o(rx_data_valid_in_i),
		.err_o(rx_err_i), .crs_o(crs_i), .col_o(col_i), .sd_o(signal_detect_in_i),
		.tx_clk_o(tx_clk_i), .txd_i(txd_o), .tx_en_i(tx_en_o), .mdc_i(mdc_o), .mdio_i(mdio_i),
		.mdio_oe_i(mdio_oe_o), .mdio_o(phy_mdio));
	initial forever #12.5 sys_clk_i = ~sys_clk_i;
	// record accepted words and any loss
	always @(posedge sys_clk_i) begin
		if (rx_valid_o && rx_ready_i) rx_q.push_back({rx_sof_o, rx_err_o, rx_data_o});
		if (rx_overflow_o) ovf = 1;
		if (tx_underrun_o) und = 1;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// nibble frame: fifth bit dropped, error and start marks kept
	task automatic t_rx();
		rx_ready_i <= 1;
		phy.send(5'h15, 0);
		phy.send(5'h1A, 1);
		phy.send(5'h07, 0);
		phy.idle();
		repeat (10) @(posedge sys_clk_i);
		check("rx count", rx_q.size(), 3);
		check("rx 0", rx_q[0], 7'h45);
		check("rx 1", rx_q[1], 7'h2A);
		check("rx 2", rx_q[2], 7'h07);
		rx_q.delete();
	endtask
	// receiver stalls: two words kept, third refused
	task automatic t_fill();
		rx_ready_i <= 0;
		phy.send(5'h01, 0);
		phy.send(5'h02, 0);
		phy.send(5'h03, 0);
		phy.idle();
		repeat (10) @(posedge sys_clk_i);
		rx_ready_i <= 1;
		repeat (4) @(posedge sys_clk_i);
		check("lost flag", ovf, 1);
		check("kept", rx_q.size(), 2);
		check("kept 0", rx_q[0], 7'h41);
		check("kept 1", rx_q[1], 7'h02);
		rx_q.delete();
	endtask
	task automatic push(input logic [4:0] d, input logic e, input logic l);
		tx_valid_i <= 1;
		tx_data_i <= d;
		tx_err_i <= e;
		tx_last_i <= l;
		do @(posedge sys_clk_i); while (!tx_ready_o);
	endtask
	// back-to-back words, one corrupted, fifth bit cleared in nibble mode
	task automatic t_tx();
		phy.tx_run = 1;
		@(posedge sys_clk_i);
		push(5'h03, 0, 0);
		push(5'h0C, 1, 0);
		push(5'h1F, 0, 1);
		tx_valid_i <= 0;
		repeat (80) @(posedge sys_clk_i);
		check("tx count", phy.tx_q.size(), 3);
		check("tx 0", phy.tx_q[0], 5'h03);
		check("tx 1", phy.tx_q[1], 5'h03);
		check("tx 2", phy.tx_q[2], 5'h0F);
		check("no cut", und, 0);
		// a frame left without its last word is cut and flagged
		push(5'h05, 0, 0);
		tx_valid_i <= 0;
		repeat (40) @(posedge sys_clk_i);
		check("cut flag", und, 1);
		check("cut count", phy.tx_q.size(), 4);
		check("cut 0", phy.tx_q[3], 5'h05);
		phy.tx_q.delete();
	endtask
	// one management write or read, picked by wr
	task automatic t_mdio(input logic wr);
		@(posedge sys_clk_i);
		mdio_write_i <= wr;
		mdio_start_i <= 1;
		@(posedge sys_clk_i);
		mdio_start_i <= 0;
		do @(posedge sys_clk_i); while (!mdio_done_o);
		if (wr) check("mdio wr", phy.cap, 16'h3C96);
		else check("mdio rd", mdio_rdata_o, 16'hA5C3);
	endtask
	// line status, then symbol mode with detect and fifth bit
	task automatic t_stat();
		#5;
		phy.col_o = 1;
		phy.crs_o = 1;
		phy.sd_o = 1;
		repeat (6) @(posedge sys_clk_i);
		check("col", col_o, 1);
		check("crs", crs_o, 1);
		check("sd nib", signal_detect_o, 0);
		sym_mode_i <= 1;
		repeat (3) @(posedge sys_clk_i);
		check("sd sym", signal_detect_o, 1);
		phy.send(5'h15, 0);
		phy.idle();
		repeat (10) @(posedge sys_clk_i);
		check("sym count", rx_q.size(), 2);
		check("sym word", rx_q[0], 7'h55);
		check("sym idle", rx_q[1], 7'h0A);
		// symbol transmit: fifth bit kept, error becomes the halt symbol
		push(5'h1F, 0, 0);
		push(5'h0C, 1, 1);
		tx_valid_i <= 0;
		repeat (60) @(posedge sys_clk_i);
		check("sym tx count", phy.tx_q.size(), 2);
		check("sym tx 0", phy.tx_q[0], 5'h1F);
		check("sym tx 1", phy.tx_q[1], 5'h04);
	endtask
	initial begin
		repeat (2) @(posedge sys_clk_i);
		srst_i <= 0;
		repeat (4) @(posedge sys_clk_i);
		t_rx();
		t_fill();
		t_tx();
		t_mdio(1);
		t_mdio(0);
		t_stat();
		give_verdict();
	end
	// hang guard, well past the expected run
	initial begin
		#400000;
		error_cnt++;
		give_verdict();
	end
endmodule // msp_mii_port_bench
`default_nettype wire
